// *** hw/vli_velocity_limit.sv ***
/*
 * Velocity limitation by two analog inputs and one digital input,
 * with its parameters reached over a fieldbus parameter port.
 * Assumes powerStageEn, torqueProfileMode, limitFuncAssigned and
 * ctrlVelMax come from logic on clk; pins and ADC words do not.
 */
`timescale 1ns/1ns
module vli_velocity_limit
  import vli_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 paramReq,
  input  wire logic                 paramWe,
  input  wire logic [15:0]          paramAddr,
  input  wire logic [31:0]          paramWdata,
  output logic                      paramAck,
  output logic                      paramErr,
  output logic [31:0]               paramRdata,
  input  wire logic                 powerStageEn,
  input  wire logic                 torqueProfileMode,
  input  wire logic [31:0]          ctrlVelMax,
  input  wire logic                 limitFuncAssigned,
  input  wire logic                 digLimitPin,
  input  wire logic [15:0]          analogInputOneSample,
  input  wire logic [15:0]          analogInputTwoSample,
  output logic [31:0]               velLimit,
  output logic                      velLimitOn,
  output vli_pkg::vli_usage_e       analog1Usage,
  output vli_pkg::vli_usage_e       analog2Usage
);
  import vli_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [31:0] digLimitFf;
  logic [15:0] an1ModeFf;
  logic [31:0] an1VmaxFf;
  logic [15:0] an2ModeFf;
  logic [31:0] an2VmaxFf;
  logic [15:0] act1ModeFf;
  logic [31:0] act1VmaxFf;
  logic [15:0] act2ModeFf;
  logic [31:0] act2VmaxFf;
  logic        psEnPrevFf;
  logic        digSync1Ff;
  logic        digSync2Ff;
  logic [15:0] an1Sync1Ff;
  logic [15:0] an1Sync2Ff;
  logic [15:0] an2Sync1Ff;
  logic [15:0] an2Sync2Ff;
  logic        ackFf;
  logic        errFf;
  logic [31:0] rdataFf;
  logic [31:0] velLimitFf;
  logic        velLimitOnFf;

  // ************************************************************
  // Parameter port decode
  // ************************************************************
  wire logic        hitDig    = paramAddr == ADDR_DIG_LIMIT;
  wire logic        hitMode1  = paramAddr == ADDR_AN1_MODE;
  wire logic        hitVmax1  = paramAddr == ADDR_AN1_VMAX;
  wire logic        hitMode2  = paramAddr == ADDR_AN2_MODE;
  wire logic        hitVmax2  = paramAddr == ADDR_AN2_VMAX;
  wire logic        hitAnalog = hitMode1 | hitVmax1 | hitMode2 | hitVmax2;
  wire logic        hitAny    = hitAnalog | hitDig;
  wire logic        vmaxOk    = paramWdata >= VMAX_MIN && paramWdata <= VEL_PARAM_MAX;
  wire logic        mode1Ok   = paramWdata <= MODE1_MAX;
  wire logic        mode2Ok   = paramWdata <= MODE2_MAX;
  wire logic        digOk     = paramWdata <= VEL_PARAM_MAX;
  wire logic        rangeOk   = (hitDig & digOk) | (hitMode1 & mode1Ok)
                              | (hitMode2 & mode2Ok) | ((hitVmax1 | hitVmax2) & vmaxOk);
  wire logic        wrLocked  = hitAnalog & powerStageEn;
  wire logic        wrErr     = paramWe & (~hitAny | wrLocked | ~rangeOk);
  wire logic        rdErr     = ~paramWe & ~hitAny;
  wire logic        wrOk      = paramReq & paramWe & ~wrErr;
  wire logic [31:0] rdMux     = hitDig   ? digLimitFf :
                                hitMode1 ? {16'h0000, an1ModeFf} :
                                hitVmax1 ? an1VmaxFf :
                                hitMode2 ? {16'h0000, an2ModeFf} :
                                hitVmax2 ? an2VmaxFf : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ackFf   <= 1'b0;
      errFf   <= 1'b0;
      rdataFf <= 32'h0000_0000;
    end else begin
      ackFf   <= paramReq;
      errFf   <= paramReq & (wrErr | rdErr);
      rdataFf <= (paramReq & ~paramWe) ? rdMux : 32'h0000_0000;
    end
  end

  // ************************************************************
  // Written settings
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      an1ModeFf  <= RST_AN1_MODE;
      an2ModeFf  <= RST_AN2_MODE;
      an1VmaxFf  <= RST_VMAX;
      an2VmaxFf  <= RST_VMAX;
      digLimitFf <= RST_DIG_LIMIT;
    end else begin
      if (wrOk & hitMode1) an1ModeFf <= paramWdata[15:0];
      if (wrOk & hitMode2) an2ModeFf <= paramWdata[15:0];
      if (wrOk & hitVmax1) an1VmaxFf <= paramWdata;
      if (wrOk & hitVmax2) an2VmaxFf <= paramWdata;
      if (wrOk & hitDig)   digLimitFf <= paramWdata;
    end
  end

  // ************************************************************
  // Settings in force, taken at stage enable
  // ************************************************************
  // An analog write cannot land while enabled, so the active copy never
  // shifts under a running motor.
  wire logic enableRise = powerStageEn & ~psEnPrevFf;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      psEnPrevFf <= 1'b0;
      act1ModeFf <= RST_AN1_MODE;
      act2ModeFf <= RST_AN2_MODE;
      act1VmaxFf <= RST_VMAX;
      act2VmaxFf <= RST_VMAX;
    end else begin
      psEnPrevFf <= powerStageEn;
      if (enableRise) begin
        act1ModeFf <= an1ModeFf;
        act2ModeFf <= an2ModeFf;
        act1VmaxFf <= an1VmaxFf;
        act2VmaxFf <= an2VmaxFf;
      end
    end
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // ADC words are assumed held steady for several cycles per sample.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      digSync1Ff <= 1'b0;
      digSync2Ff <= 1'b0;
      an1Sync1Ff <= 16'h0000;
      an1Sync2Ff <= 16'h0000;
      an2Sync1Ff <= 16'h0000;
      an2Sync2Ff <= 16'h0000;
    end else begin
      digSync1Ff <= digLimitPin;
      digSync2Ff <= digSync1Ff;
      an1Sync1Ff <= analogInputOneSample;
      an1Sync2Ff <= an1Sync1Ff;
      an2Sync1Ff <= analogInputTwoSample;
      an2Sync2Ff <= an2Sync1Ff;
    end
  end

  // ************************************************************
  // Analog scaling stages
  // ************************************************************
  vli_scale_if scOne ();
  vli_scale_if scTwo ();

  // first input scaled by its vmax
  assign scOne.sample  = an1Sync2Ff;
  assign scOne.vmax    = act1VmaxFf;
  assign scOne.ctrlMax = ctrlVelMax;
  // second input scaled by its vmax
  assign scTwo.sample  = an2Sync2Ff;
  assign scTwo.vmax    = act2VmaxFf;
  assign scTwo.ctrlMax = ctrlVelMax;

  vli_analog_scale uScaleOne (
    .clk  (clk),
    .nrst (nrst),
    .sc   (scOne.scaler)
  );

  vli_analog_scale uScaleTwo (
    .clk  (clk),
    .nrst (nrst),
    .sc   (scTwo.scaler)
  );

  // ************************************************************
  // Limit selection
  // ************************************************************
  // usage decode
  wire logic        lim1On = act1ModeFf == {13'h0000, USE_VEL_LIMIT};
  wire logic        lim2On = act2ModeFf == {13'h0000, USE_VEL_LIMIT};
  wire logic        digOn  = digSync2Ff & limitFuncAssigned;
  wire logic [31:0] digEff = (torqueProfileMode && digLimitFf < FLOOR_VEL) ?
                             FLOOR_VEL : digLimitFf;
  wire logic [31:0] cand1  = lim1On ? scOne.limit : VEL_PARAM_MAX;
  wire logic [31:0] cand2  = lim2On ? scTwo.limit : VEL_PARAM_MAX;
  wire logic [31:0] cand3  = digOn ? digEff : VEL_PARAM_MAX;
  wire logic [31:0] min12  = (cand1 < cand2) ? cand1 : cand2;
  wire logic [31:0] minAll = (min12 < cand3) ? min12 : cand3;
  wire logic        anyOn  = lim1On | lim2On | digOn;
  // With no cap active the controller maximum is reported
  wire logic [31:0] nxtVelLimit = anyOn ? minAll : ctrlVelMax;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      velLimitFf   <= 32'h0000_0000;
      velLimitOnFf <= 1'b0;
    end else begin
      velLimitFf   <= nxtVelLimit;
      velLimitOnFf <= anyOn;
    end
  end

  assign paramAck     = ackFf;
  assign paramErr     = errFf;
  assign paramRdata   = rdataFf;
  assign velLimit     = velLimitFf;
  assign velLimitOn   = velLimitOnFf;
  assign analog1Usage = vli_usage_e'(act1ModeFf[2:0]);
  assign analog2Usage = vli_usage_e'(act2ModeFf[2:0]);

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence sWriteLocked;
    paramReq && paramWe && powerStageEn && hitAnalog;
  endsequence
  sequence sEnableRise;
    powerStageEn && !psEnPrevFf;
  endsequence

  a_locked_reject: assert property (sWriteLocked |=> paramErr && paramAck
      && $stable(an1ModeFf) && $stable(an1VmaxFf) && $stable(an2ModeFf) && $stable(an2VmaxFf))
    else $error("analog setting written while stage enabled");
  a_mode1_range: assert property (paramReq && paramWe && hitMode1
      && paramWdata > MODE1_MAX |=> paramErr && $stable(an1ModeFf))
    else $error("first usage code out of range accepted");
  a_mode2_reserved: assert property (paramReq && paramWe && hitMode2
      && paramWdata == MODE2_MAX && !powerStageEn |=> !paramErr && an2ModeFf == 16'h0005)
    else $error("reserved second usage code refused");
  a_apply_enable: assert property (sEnableRise |=> act1VmaxFf == $past(an1VmaxFf)
      && act2ModeFf == $past(an2ModeFf))
    else $error("settings not applied at stage enable");
  a_hold_active: assert property (!enableRise |=> $stable(act1ModeFf)
      && $stable(act2VmaxFf))
    else $error("active settings changed without enable edge");
  a_reset_values: assert property (@(posedge clk) disable iff (1'b0) !nrst
      |=> an1ModeFf == RST_AN1_MODE && digLimitFf == RST_DIG_LIMIT && an1VmaxFf == RST_VMAX)
    else $error("wrong value after reset");
  a_dig_range: assert property (paramReq && paramWe && hitDig && paramWdata[31]
      |=> paramErr && $stable(digLimitFf))
    else $error("digital limit out of range accepted");
  a_digital_cap: assert property (digOn && !torqueProfileMode
      |=> velLimitOn && velLimit <= $past(digLimitFf))
    else $error("digital cap not applied");
  a_torque_floor: assert property (digOn && torqueProfileMode && !lim1On && !lim2On
      |=> velLimit >= FLOOR_VEL)
    else $error("torque profile digital limit below floor");
  a_unassigned_pin: assert property (digSync2Ff && !limitFuncAssigned
      && !lim1On && !lim2On |=> !velLimitOn)
    else $error("digital limit acted without assignment");

  // ************************************************************
  // Port and selection checks
  // ************************************************************
  sequence sDigWrite;
    paramReq && paramWe && hitDig && digOk;
  endsequence
  sequence sShadowWrite;
    paramReq && paramWe && hitVmax1 && !powerStageEn && vmaxOk;
  endsequence

  a_ack_follows: assert property (paramReq |=> paramAck)
    else $error("request without acknowledge");
  a_ack_idle: assert property (!paramReq |=> !paramAck && !paramErr)
    else $error("acknowledge without request");
  a_unmapped_err: assert property (paramReq && !hitAny |=> paramErr)
    else $error("unmapped address accepted");
  a_dig_write: assert property (sDigWrite
      |=> !paramErr && digLimitFf == $past(paramWdata))
    else $error("digital limit write lost");
  a_shadow_write: assert property (sShadowWrite
      |=> an1VmaxFf == $past(paramWdata))
    else $error("first vmax write lost with stage disabled");
  a_dig_readback: assert property (paramReq && !paramWe && hitDig
      |=> paramRdata == $past(digLimitFf))
    else $error("digital limit read back wrong");
  a_idle_ceiling: assert property (!anyOn
      |=> !velLimitOn && velLimit == $past(ctrlVelMax))
    else $error("no cap active but limit not controller maximum");

endmodule : vli_velocity_limit

// *** hw/vli_pkg.sv ***
/*
 * Constants, parameter addresses and usage codes for the velocity limiter.
 * Assumes a single 100 MHz clock and a synchronous active-low reset.
 */
package vli_pkg;

  // ************************************************************
  // Parameter addresses
  // ************************************************************
  localparam logic [15:0] ADDR_DIG_LIMIT = 16'h063c;
  localparam logic [15:0] ADDR_AN1_MODE  = 16'h091c;
  localparam logic [15:0] ADDR_AN1_VMAX  = 16'h0920;
  localparam logic [15:0] ADDR_AN2_MODE  = 16'h0926;
  localparam logic [15:0] ADDR_AN2_VMAX  = 16'h092a;

  // ************************************************************
  // Reset values and ranges
  // ************************************************************
  localparam logic [31:0] RST_DIG_LIMIT  = 32'h0000_000a;
  localparam logic [15:0] RST_AN1_MODE   = 16'h0001;
  localparam logic [15:0] RST_AN2_MODE   = 16'h0000;
  localparam logic [31:0] RST_VMAX       = 32'h0000_0bb8;
  localparam logic [31:0] VMAX_MIN       = 32'h0000_0001;
  localparam logic [31:0] VEL_PARAM_MAX  = 32'h7fff_ffff;
  localparam logic [31:0] MODE1_MAX      = 32'h0000_0004;
  localparam logic [31:0] MODE2_MAX      = 32'h0000_0005;
  localparam logic [31:0] FLOOR_VEL      = 32'h0000_0064;

  // ************************************************************
  // Analog sample scaling: code 0x4000 stands for 10 V
  // ************************************************************
  localparam logic signed [15:0] AN_FULL_SCALE = 16'sh4000;
  localparam int                 AN_SHIFT      = 14;

  typedef enum logic [2:0] {
    USE_NONE       = 3'h0,
    USE_TARGET_VEL = 3'h1,
    USE_TARGET_TRQ = 3'h2,
    USE_VEL_LIMIT  = 3'h3,
    USE_CUR_LIMIT  = 3'h4,
    USE_RESERVED   = 3'h5
  } vli_usage_e;

endpackage : vli_pkg

// *** hw/vli_scale_if.sv ***
/*
 * Carrier between the limiter top and one analog scaling stage.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface vli_scale_if;
  logic signed [15:0] sample;
  logic        [31:0] vmax;
  logic        [31:0] ctrlMax;
  logic        [31:0] limit;

  modport scaler (input sample, input vmax, input ctrlMax, output limit);
  modport user   (output sample, output vmax, output ctrlMax, input limit);
endinterface : vli_scale_if

// *** hw/vli_analog_scale.sv ***
/*
 * One analog input turned into a velocity limit, registered.
 * Assumes a synchronised sample and settled vmax and ctrlMax.
 */
`timescale 1ns/1ns
module vli_analog_scale
  import vli_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   nrst,
  vli_scale_if.scaler sc
);

  logic [15:0] code;
  logic [47:0] product;
  logic [31:0] scaled;
  logic [31:0] floored;
  logic [31:0] capped;
  logic [31:0] limitFf;

  // Negative input means no headroom; above 10 V saturates
  assign code = (sc.sample < 16'sh0000) ? 16'h0000 :
                (sc.sample > AN_FULL_SCALE) ? AN_FULL_SCALE : sc.sample;
  assign product = {16'h0000, sc.vmax} * {32'h0000_0000, code};
  assign scaled  = product[AN_SHIFT +: 32];
  assign floored = (scaled < FLOOR_VEL) ? FLOOR_VEL : scaled;
  assign capped  = (floored > sc.ctrlMax) ? sc.ctrlMax : floored;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      limitFf <= FLOOR_VEL;
    end else begin
      limitFf <= capped;
    end
  end

  assign sc.limit = limitFf;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_floor_hold: assert property (sc.ctrlMax >= FLOOR_VEL |=> limitFf >= FLOOR_VEL)
    else $error("analog limit below floor");
  a_ceiling_hold: assert property (1'b1 |=> limitFf <= $past(sc.ctrlMax))
    else $error("analog limit above controller maximum");
  a_full_scale: assert property (sc.sample >= AN_FULL_SCALE && sc.vmax >= FLOOR_VEL
      && sc.vmax <= sc.ctrlMax |=> limitFf == $past(sc.vmax))
    else $error("full scale input does not give vmax");
  a_half_scale: assert property (sc.sample == 16'sh2000 && !sc.vmax[0]
      && (sc.vmax >> 1) >= FLOOR_VEL && sc.vmax <= sc.ctrlMax
      |=> limitFf == ($past(sc.vmax) >> 1))
    else $error("half scale input does not give half vmax");

endmodule : vli_analog_scale

// *** sim/vli_field_model.sv ***
/*
 * Model of the analog voltage sources and the digital limit pin.
 * Assumes the bench gives wanted ADC codes; levels move on falling edges.
 */
`timescale 1ns/1ns
module vli_field_model (
  input  wire logic        clk,
  input  wire logic [15:0] wantOne,
  input  wire logic [15:0] wantTwo,
  input  wire logic        wantPin,
  output logic      [15:0] analogOne,
  output logic      [15:0] analogTwo,
  output logic             limitPin
);
  // Sources settle between edges, never at the sampling edge
  always @(negedge clk) begin
    analogOne <= wantOne;
    analogTwo <= wantTwo;
    limitPin  <= wantPin;
  end
endmodule : vli_field_model

// *** sim/test_vli_velocity_limit.sv ***
/*
 * Self-checking bench for the velocity limiter, random with corner cases.
 * Assumes the design package and the field model are compiled first.
 */
`timescale 1ns/1ns
module test_vli_velocity_limit;
  import vli_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, paramReq = 1'b0, paramWe = 1'b0;
  logic [15:0] paramAddr = 16'h0000, wOne = 16'h0000, wTwo = 16'h0000;
  logic [31:0] paramWdata = 32'h0000_0000, ctrlVelMax = 32'h7fff_ffff;
  logic        powerStageEn = 1'b0, torqueProfileMode = 1'b0;
  logic        limitFuncAssigned = 1'b0, wPin = 1'b0, pin, paramAck, paramErr, velLimitOn;
  logic [15:0] an1, an2;
  logic [31:0] paramRdata, velLimit, v1, v2, dig, e1, e2;
  vli_usage_e  analog1Usage, analog2Usage;
  logic [2:0]  m1, m2;
  int          errTotal = 0, checksDone = 0;

  always #5 clk = ~clk;

  vli_field_model vli_field_model_i (.clk(clk), .wantOne(wOne), .wantTwo(wTwo),
    .wantPin(wPin), .analogOne(an1), .analogTwo(an2), .limitPin(pin));

  vli_velocity_limit vli_velocity_limit_i (.clk(clk), .nrst(nrst), .paramReq(paramReq),
    .paramWe(paramWe), .paramAddr(paramAddr), .paramWdata(paramWdata),
    .paramAck(paramAck), .paramErr(paramErr), .paramRdata(paramRdata),
    .powerStageEn(powerStageEn), .torqueProfileMode(torqueProfileMode),
    .ctrlVelMax(ctrlVelMax), .limitFuncAssigned(limitFuncAssigned),
    .digLimitPin(pin), .analogInputOneSample(an1), .analogInputTwoSample(an2),
    .velLimit(velLimit), .velLimitOn(velLimitOn),
    .analog1Usage(analog1Usage), .analog2Usage(analog2Usage));

  task automatic stopTest;
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stopTest

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Analog path: clip the code, scale, floor, then ceiling
  function automatic logic [31:0] anLim(input logic [31:0] vm, input logic [15:0] s);
    logic [63:0] p;
    logic [15:0] c;
    c = s[15] ? 16'h0000 : ((s > 16'h4000) ? 16'h4000 : s);
    p = ({32'h0000_0000, vm} * {48'h0000_0000_0000, c}) >> 14;
    if (p < 64'd100) p = 64'd100;
    if (p > {32'h0000_0000, ctrlVelMax}) p = {32'h0000_0000, ctrlVelMax};
    return p[31:0];
  endfunction : anLim

  // Minimum of the caps in force; none leaves ctrlVelMax
  // Digital cap is not clamped by ctrlVelMax
  function automatic logic [32:0] expLim();
    logic [31:0] lim;
    logic [31:0] d;
    logic        on;
    lim = VEL_PARAM_MAX;
    d   = (torqueProfileMode && dig < 32'd100) ? 32'd100 : dig;
    if (m1 == 3'h3) lim = (e1 < lim) ? e1 : lim;
    if (m2 == 3'h3) lim = (e2 < lim) ? e2 : lim;
    if (limitFuncAssigned && wPin) lim = (d < lim) ? d : lim;
    on  = (m1 == 3'h3) || (m2 == 3'h3) || (limitFuncAssigned && wPin);
    if (!on) lim = ctrlVelMax;
    return {on, lim};
  endfunction : expLim

  task automatic access(input logic we, input logic [15:0] a, input logic [31:0] d,
                        output logic err, output logic [31:0] rd);
    int n;
    @(negedge clk);
    paramReq   = 1'b1;
    paramWe    = we;
    paramAddr  = a;
    paramWdata = d;
    @(negedge clk);
    paramReq = 1'b0;
    for (n = 0; n < 4 && paramAck !== 1'b1; n++) @(negedge clk);
    if (n == 4) begin errTotal++; $display("no answer at %0t", $time); stopTest(); end
    err = paramErr;
    rd  = paramRdata;
  endtask : access

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic expErr);
    logic        e;
    logic [31:0] r;
    access(1'b1, a, d, e, r);
    check({31'h0, e}, {31'h0, expErr});
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic expErr);
    logic        e;
    logic [31:0] r;
    access(1'b0, a, 32'h0000_0000, e, r);
    check({31'h0, e}, {31'h0, expErr});
    if (!expErr) check(r, exp);
  endtask : rd

  task automatic stage(input logic on);
    @(negedge clk);
    powerStageEn = on;
    repeat (3) @(negedge clk);
  endtask : stage

  task automatic checkLimit;
    logic [32:0] x;
    repeat (7) @(negedge clk);
    x = expLim();
    check({31'h0, velLimitOn}, {31'h0, x[32]});
    check(velLimit, x[31:0]);
  endtask : checkLimit

  initial begin
    void'($urandom(28));
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    check(velLimit, 32'h0000_0000);
    check({31'h0, velLimitOn | paramAck}, 32'h0000_0000);
    // ************************************************************
    // Reset values
    // ************************************************************
    check({29'h0, analog1Usage}, 32'h0000_0001);
    check({29'h0, analog2Usage}, 32'h0000_0000);
    rd(ADDR_AN1_MODE, 32'h0000_0001, 1'b0);
    rd(ADDR_AN2_MODE, 32'h0000_0000, 1'b0);
    rd(ADDR_AN1_VMAX, 32'h0000_0bb8, 1'b0);
    rd(ADDR_AN2_VMAX, 32'h0000_0bb8, 1'b0);
    rd(ADDR_DIG_LIMIT, 32'h0000_000a, 1'b0);
    rd(16'h0920 + 16'h0002, 32'h0000_0000, 1'b1);
    $display("reset test done");
    // ************************************************************
    // Range refusals and locked writes
    // ************************************************************
    wr(ADDR_AN1_MODE, 32'h0000_0005, 1'b1);
    wr(ADDR_AN2_MODE, 32'h0000_0006, 1'b1);
    wr(ADDR_AN1_VMAX, 32'h0000_0000, 1'b1);
    wr(ADDR_AN2_VMAX, 32'h8000_0000, 1'b1);
    wr(ADDR_DIG_LIMIT, 32'h8000_0000, 1'b1);
    wr(ADDR_DIG_LIMIT, 32'h0000_0000, 1'b0);
    stage(1'b1);
    wr(ADDR_AN1_VMAX, 32'h0000_0064, 1'b1);
    wr(ADDR_AN2_MODE, 32'h0000_0003, 1'b1);
    rd(ADDR_AN1_VMAX, 32'h0000_0bb8, 1'b0);
    $display("refusal test done");
    // ************************************************************
    // Every usage code, applied only at stage enable
    // ************************************************************
    m1 = 3'h1;
    for (int k = 0; k < 6; k++) begin
      stage(1'b0);
      if (k < 5) wr(ADDR_AN1_MODE, k, 1'b0);
      wr(ADDR_AN2_MODE, k, 1'b0);
      check({29'h0, analog1Usage}, {29'h0, m1});
      stage(1'b1);
      if (k < 5) m1 = k[2:0];
      m2 = k[2:0];
      check({29'h0, analog1Usage}, {29'h0, m1});
      check({29'h0, analog2Usage}, {29'h0, m2});
    end
    $display("usage test done");
    // ************************************************************
    // Analog scaling, floor and ceiling
    // ************************************************************
    dig = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      stage(1'b0);
      v1 = (i == 0) ? 32'h7fff_ffff : (i == 4) ? 32'h0000_1000 : ($urandom % 32'h0001_0000) + 32'd1;
      v2 = (i == 1) ? 32'h0000_0001 : ($urandom % 32'h0000_4000) + 32'd1;
      wr(ADDR_AN1_MODE, 32'h0000_0003, 1'b0);
      wr(ADDR_AN2_MODE, 32'h0000_0003, 1'b0);
      wr(ADDR_AN1_VMAX, v1, 1'b0);
      wr(ADDR_AN2_VMAX, v2, 1'b0);
      stage(1'b1);
      m1 = 3'h3;
      m2 = 3'h3;
      ctrlVelMax = (i == 2) ? 32'd50 : (i == 4) ? 32'h0001_0000 : ($urandom % 32'h0002_0000);
      wOne = (i == 0) ? 16'h7fff : ((i == 4) ? 16'h2000 : $urandom);
      wTwo = (i == 1) ? 16'h0000 : ((i == 3) ? 16'h4000 : $urandom);
      e1 = anLim(v1, wOne);
      e2 = anLim(v2, wTwo);
      checkLimit();
    end
    $display("analog test done");
    // ************************************************************
    // Digital limit, immediate while the stage runs
    // ************************************************************
    stage(1'b0);
    wr(ADDR_AN1_MODE, 32'h0000_0000, 1'b0);
    wr(ADDR_AN2_MODE, 32'h0000_0000, 1'b0);
    stage(1'b1);
    m1 = 3'h0;
    m2 = 3'h0;
    ctrlVelMax = 32'h0001_0000;
    for (int i = 0; i < 12; i++) begin
      // function assigned first, except in a few rounds
      limitFuncAssigned = (i % 4 != 3);
      torqueProfileMode = (i == 0) ? 1'b1 : ((i == 1) ? 1'b0 : $urandom);
      wPin = (i != 5);
      dig = (i < 2) ? 32'd99 - i : $urandom % 32'h0000_0400;
      wr(ADDR_DIG_LIMIT, dig, 1'b0);
      checkLimit();
    end
    $display("digital test done");
    stopTest();
  end

  initial begin
    repeat (60000) @(posedge clk);
    errTotal++;
    stopTest();
  end
endmodule : test_vli_velocity_limit
